// ==== rtl/cdv_pkg.sv ====
// Constants and carrier types for the codec digital volume block
package cdv_pkg;

  // Register offsets, one 8-bit register per index
  localparam logic [3:0] OFS_ADC1_LEFT_VOLUME = 4'h0;
  localparam logic [3:0] OFS_ADC1_RIGHT_VOLUME = 4'h1;
  localparam logic [3:0] OFS_ADC2_LEFT_VOLUME = 4'h2;
  localparam logic [3:0] OFS_ADC2_RIGHT_VOLUME = 4'h3;
  localparam logic [3:0] OFS_DAC_LEFT_VOLUME = 4'h4;
  localparam logic [3:0] OFS_DAC_RIGHT_VOLUME = 4'h5;
  localparam logic [3:0] OFS_CONTROL = 4'h6;
  localparam logic [3:0] OFS_STATUS = 4'h7;

  // Control register field positions
  localparam int CTL_ADC1_SOFT_MUTE = 7;
  localparam int CTL_ADC2_SOFT_MUTE = 6;
  localparam int CTL_ADC_RAMP_SPEED = 5;
  localparam int CTL_DAC_RAMP_SPEED = 4;
  localparam int CTL_DEEMPH_LSB = 0;

  // Values after reset or power-down
  localparam logic [7:0] ADC_VOL_RST = 8'h30;
  localparam logic [7:0] DAC_VOL_RST = 8'h18;
  localparam logic [7:0] CONTROL_RST = 8'h00;

  // Fine level scale: four fine levels per code, 1021 levels in all
  localparam logic [9:0] FINE_MAX = 10'h3fc;
  localparam logic [9:0] LEVEL_ADC_RST = {ADC_VOL_RST, 2'b00};
  localparam logic [9:0] LEVEL_DAC_RST = {DAC_VOL_RST, 2'b00};

  // Frames per step at slow speed, counted 0 to 3
  localparam logic [1:0] SLOW_LAST = 2'h3;

  // Channel count and how many of them belong to the ADC paths
  localparam int NUM_CH = 6;
  localparam int NUM_ADC_CH = 4;

  // De-emphasis filter modes
  typedef enum logic [1:0] {
    DEEMPH_OFF,
    DEEMPH_48K,
    DEEMPH_44K1,
    DEEMPH_32K
  } cdv_deemph_type;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } cdv_bus_req_type;

  typedef logic [9:0] cdv_level_type;
  typedef logic [NUM_CH-1:0][9:0] cdv_levels_type;
  typedef logic [NUM_CH-1:0][7:0] cdv_vols_type;

  // Volume codes after reset, index 0 is the first ADC left channel
  localparam cdv_vols_type VOLS_RST = {DAC_VOL_RST, DAC_VOL_RST,
    ADC_VOL_RST, ADC_VOL_RST, ADC_VOL_RST, ADC_VOL_RST};
  localparam cdv_levels_type LEVELS_RST = {LEVEL_DAC_RST, LEVEL_DAC_RST,
    LEVEL_ADC_RST, LEVEL_ADC_RST, LEVEL_ADC_RST, LEVEL_ADC_RST};

endpackage

// ==== rtl/cdv_volume.sv ====
// Digital volume ramps, ADC soft mute and de-emphasis select
//
// Overview of operation
// - ADC mute ramps attenuation up to silence
// - Mute release ramps back to programmed volume
// - Early release reverses ramp at same rate
// - Full mute ramp 828 frames, slow four times
// - ADC speed bit: one or four frames/step
// - Mute acts only while ADC is running
// - Power-down pin reinitialises ADC attenuation
// - Four independent 8-bit ADC volumes
// - ADC code 30h 0dB, 0.5dB steps, FFh mute
// - ADC full code ramp takes 1021 levels
// - Power-down resets all four ADC volumes to 30h
// - Two-bit de-emphasis select chooses filter mode
// - DAC code 18h 0dB, 0.5dB steps, FFh mute
// - DAC speed bit: one or four frames/step
// - DAC full code ramp takes 1021 levels
// - Power-down resets DAC volumes to 18h
//
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/100ps

module cdv_volume (
  input wire logic clock,
  input wire logic rst_b,
  input wire cdv_pkg::cdv_bus_req_type regReq,
  output logic [7:0] regRdata,
  input wire logic sampleFrameClock,
  input wire logic powerDownPin_b,
  input wire logic adcRunning,
  output cdv_pkg::cdv_levels_type gainLevel,
  output logic [cdv_pkg::NUM_CH-1:0] rampBusy,
  output cdv_pkg::cdv_deemph_type deemphasisSelect
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Fine target of a channel: code scaled by four, or silence
  function automatic cdv_pkg::cdv_level_type fineTarget(
    input logic [7:0] code,
    input logic silence
  );
    fineTarget = silence ? cdv_pkg::FINE_MAX : {code, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] frameSync; // Frame clock pin, three stages
  logic frameLevel; // Debounced frame clock level
  logic frameTick; // One cycle per new sample frame
  logic [2:0] pdnSync; // Power-down pin, three stages
  logic pdnActive; // Power-down seen and held

  // Shift pins in; stage 0 feeds only stage 1
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frameSync <= 3'h0;
      pdnSync <= 3'h7;
    end
    else
    begin
      frameSync <= {frameSync[1:0], sampleFrameClock};
      pdnSync <= {pdnSync[1:0], powerDownPin_b};
    end
  end

  // Level moves only once the last two stages agree
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      frameLevel <= 1'b0;
    else if (frameSync[2] == frameSync[1])
      frameLevel <= frameSync[1];
  end

  // Rising frame edge once it is stable
  assign frameTick = frameSync[2] & frameSync[1] & !frameLevel;

  // Power-down latches while the pin is low, agreed by two stages
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      pdnActive <= 1'b0;
    else if (!pdnSync[2] && !pdnSync[1])
      pdnActive <= 1'b1;
    else if (pdnSync[2] && pdnSync[1])
      pdnActive <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file

  cdv_pkg::cdv_vols_type volume; // Programmed volume codes
  logic [7:0] control; // Mute, speed and de-emphasis bits
  logic adc1Mute; // First ADC path soft mute
  logic adc2Mute; // Second ADC path soft mute
  logic adcSlow; // ADC ramp at four frames per step
  logic dacSlow; // DAC ramp at four frames per step

  assign adc1Mute = control[cdv_pkg::CTL_ADC1_SOFT_MUTE];
  assign adc2Mute = control[cdv_pkg::CTL_ADC2_SOFT_MUTE];
  assign adcSlow = control[cdv_pkg::CTL_ADC_RAMP_SPEED];
  assign dacSlow = control[cdv_pkg::CTL_DAC_RAMP_SPEED];

  // Volume writes; power-down overrides a write in the same cycle
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      volume <= cdv_pkg::VOLS_RST;
    else if (pdnActive)
      volume <= cdv_pkg::VOLS_RST;
    else if (regReq.write && regReq.addr < 4'(cdv_pkg::NUM_CH))
      volume[regReq.addr[2:0]] <= regReq.wdata;
  end

  // Control writes
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      control <= cdv_pkg::CONTROL_RST;
    else if (pdnActive)
      control <= cdv_pkg::CONTROL_RST;
    else if (regReq.write && regReq.addr == cdv_pkg::OFS_CONTROL)
      control <= regReq.wdata;
  end

  // De-emphasis mode straight from its register field
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      deemphasisSelect <= cdv_pkg::DEEMPH_OFF;
    else
      deemphasisSelect <= cdv_pkg::cdv_deemph_type'(
        control[cdv_pkg::CTL_DEEMPH_LSB +: 2]);
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      regRdata <= 8'h00;
    else if (!regReq.read)
      regRdata <= 8'h00;
    else if (regReq.addr < 4'(cdv_pkg::NUM_CH))
      regRdata <= volume[regReq.addr[2:0]];
    else if (regReq.addr == cdv_pkg::OFS_CONTROL)
      regRdata <= control;
    else if (regReq.addr == cdv_pkg::OFS_STATUS)
      regRdata <= {2'b00, rampBusy};
    else
      regRdata <= 8'h00; // Unmapped reads as zero
  end

  ////////////////////////////////////////////////////////////////////////
  // Step interval

  logic [1:0] adcDiv; // Frame count within a slow ADC step
  logic [1:0] dacDiv; // Frame count within a slow DAC step
  logic adcStep; // ADC channels may move one level
  logic dacStep; // DAC channels may move one level

  // Count frames; shared by all channels of a path
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      adcDiv <= 2'h0;
      dacDiv <= 2'h0;
    end
    else if (pdnActive)
    begin
      adcDiv <= 2'h0;
      dacDiv <= 2'h0;
    end
    else if (frameTick)
    begin
      adcDiv <= adcDiv + 2'h1;
      dacDiv <= dacDiv + 2'h1;
    end
  end

  // Fast: every frame; slow: every fourth frame
  assign adcStep = frameTick &&
    (!adcSlow || adcDiv == cdv_pkg::SLOW_LAST);
  assign dacStep = frameTick &&
    (!dacSlow || dacDiv == cdv_pkg::SLOW_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Attenuation ramps

  cdv_pkg::cdv_levels_type target; // Level each channel heads for
  cdv_pkg::cdv_levels_type next_gainLevel; // Level after this cycle
  logic [cdv_pkg::NUM_CH-1:0] chStep; // Step enable per channel
  logic [cdv_pkg::NUM_CH-1:0] chMute; // Effective mute per channel

  // Targets and one-level moves; a stopped ADC ignores its mute bit
  always_comb
  begin
    for (int ch = 0; ch < cdv_pkg::NUM_CH; ch++)
    begin
      if (ch < 2)
        chMute[ch] = adc1Mute && adcRunning;
      else if (ch < cdv_pkg::NUM_ADC_CH)
        chMute[ch] = adc2Mute && adcRunning;
      else
        chMute[ch] = 1'b0;
      chStep[ch] = (ch < cdv_pkg::NUM_ADC_CH) ? adcStep : dacStep;
      // Code FFh lands on the top fine level, i.e. silence
      target[ch] = fineTarget(volume[ch], chMute[ch]);
      rampBusy[ch] = gainLevel[ch] != target[ch];
      next_gainLevel[ch] = gainLevel[ch];
      // Direction follows the live target, so release reverses at once
      if (chStep[ch] && gainLevel[ch] < target[ch])
        next_gainLevel[ch] = gainLevel[ch] + 10'h001;
      else if (chStep[ch] && gainLevel[ch] > target[ch])
        next_gainLevel[ch] = gainLevel[ch] - 10'h001;
    end
  end

  // Applied levels; 1020 single steps span the whole code range
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      gainLevel <= cdv_pkg::LEVELS_RST;
    else if (pdnActive)
      gainLevel <= cdv_pkg::LEVELS_RST;
    else
      gainLevel <= next_gainLevel;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // Fine level never leaves the span
  a_level_span: assert property (
    gainLevel[0] <= cdv_pkg::FINE_MAX && gainLevel[4] <= cdv_pkg::FINE_MAX)
    else $error("fine level out of span");

  // Level moves by at most one
  // A power-down seen one edge later may jump the level to its reset
  a_single_step: assert property (
    !pdnActive |=> pdnActive || (gainLevel[1] == $past(gainLevel[1]) ||
      gainLevel[1] == $past(gainLevel[1]) + 10'h001 ||
      gainLevel[1] == $past(gainLevel[1]) - 10'h001))
    else $error("level jumped more than one");

  // No movement between step moments
  a_step_only: assert property (
    !adcStep && !pdnActive |=> pdnActive || $stable(gainLevel[0]))
    else $error("ADC level moved without a step");

  // Slow DAC steps at most once per four frames
  a_dac_slow: assert property (
    dacSlow && frameTick && dacDiv != cdv_pkg::SLOW_LAST && !pdnActive
      |=> pdnActive || $stable(gainLevel[5]))
    else $error("slow DAC stepped early");

  // Muted running ADC climbs toward silence
  a_mute_climb: assert property (
    adc1Mute && adcRunning && adcStep && !pdnActive &&
      gainLevel[0] < cdv_pkg::FINE_MAX
      |=> pdnActive || gainLevel[0] == $past(gainLevel[0]) + 10'h001)
    else $error("mute ramp not climbing");

  // Released mute falls back toward volume
  a_release_fall: assert property (
    !adc2Mute && adcStep && !pdnActive &&
      gainLevel[2] > {volume[2], 2'b00}
      |=> pdnActive || gainLevel[2] == $past(gainLevel[2]) - 10'h001)
    else $error("release not ramping back");

  // Stopped ADC ignores mute
  a_stopped_hold: assert property (
    !adcRunning && !pdnActive && gainLevel[0] == {volume[0], 2'b00}
      && !(regReq.write && regReq.addr == cdv_pkg::OFS_ADC1_LEFT_VOLUME)
      |=> pdnActive || gainLevel[0] == $past(gainLevel[0]))
    else $error("stopped ADC level moved");

  // Power-down restores volumes and levels
  a_pdn_init: assert property (
    pdnActive |=> volume[0] == cdv_pkg::ADC_VOL_RST &&
      volume[4] == cdv_pkg::DAC_VOL_RST &&
      gainLevel[1] == cdv_pkg::LEVEL_ADC_RST)
    else $error("power-down did not reinitialise");

  // Power-down restores DAC right volume
  a_pdn_dac: assert property (
    pdnActive |=> volume[5] == cdv_pkg::DAC_VOL_RST &&
      gainLevel[5] == cdv_pkg::LEVEL_DAC_RST)
    else $error("DAC not reinitialised");

  // De-emphasis follows the control field one cycle later
  a_deemph_mode: assert property (
    regReq.write && regReq.addr == cdv_pkg::OFS_CONTROL && !pdnActive
      |=> ##1 deemphasisSelect == $past(regReq.wdata[1:0], 2))
    else $error("de-emphasis select wrong");

  ////////////////////////////////////////////////////////////////////////
  // Further checks on pacing, DAC ramps and the register port

  // Slow ADC holds between its fourth-frame steps
  // Shared divider, so all four ADC channels share the phase
  a_adc_slow: assert property (
    adcSlow && frameTick && adcDiv != cdv_pkg::SLOW_LAST && !pdnActive
      |=> pdnActive || $stable(gainLevel[3]))
    else $error("slow ADC stepped early");

  // DAC level moves only on a DAC step moment
  a_dac_pace: assert property (
    !dacStep && !pdnActive |=> pdnActive || $stable(gainLevel[4]))
    else $error("DAC level moved without a step");

  // DAC climbs one level toward a quieter code
  a_dac_climb: assert property (
    dacStep && !pdnActive && gainLevel[4] < {volume[4], 2'b00}
      |=> pdnActive || gainLevel[4] == $past(gainLevel[4]) + 10'h001)
    else $error("DAC not climbing toward code");

  // DAC falls one level toward a louder code
  a_dac_fall: assert property (
    dacStep && !pdnActive && gainLevel[5] > {volume[5], 2'b00}
      |=> pdnActive || gainLevel[5] == $past(gainLevel[5]) - 10'h001)
    else $error("DAC not falling toward code");

  // A fully muted running channel stays silent
  a_mute_held: assert property (
    adc1Mute && adcRunning && !pdnActive &&
      gainLevel[1] == cdv_pkg::FINE_MAX
      |=> pdnActive || gainLevel[1] == cdv_pkg::FINE_MAX)
    else $error("muted channel left silence");

  // Power-down turns the de-emphasis filter off two edges on
  a_deemph_pdn: assert property (
    pdnActive |=> ##1 deemphasisSelect == cdv_pkg::DEEMPH_OFF)
    else $error("de-emphasis not cleared by power-down");

  // Read data stands one cycle only; idle port reads zero
  a_read_idle: assert property (
    !regReq.read |=> regRdata == 8'h00)
    else $error("read data outside its cycle");

  // One tick per frame edge, else ramps would run double speed
  a_tick_single: assert property (
    frameTick |=> !frameTick)
    else $error("frame tick longer than a cycle");

  // Stopped ADC still tracks a new volume code
  // The mute bit is ignored, so the level heads for the code itself
  a_stopped_track: assert property (
    !adcRunning && adcStep && !pdnActive &&
      gainLevel[1] < {volume[1], 2'b00}
      |=> pdnActive || gainLevel[1] == $past(gainLevel[1]) + 10'h001)
    else $error("stopped ADC not tracking code");

  // Main scenarios
  c_mute_done: cover property (
    adc1Mute && gainLevel[0] == cdv_pkg::FINE_MAX);
  c_mute_abort: cover property (
    adc1Mute ##1 !adc1Mute && gainLevel[0] < cdv_pkg::FINE_MAX);
  c_dac_ramp: cover property (rampBusy[4] && dacStep);
  c_pdn: cover property (pdnActive);

endmodule // cdv_volume

// ==== testbench/tb_codec_digital_volume_soft_mute.sv ====
// Self-checking bench for the codec digital volume block
`timescale 1ns/100ps

module tb_codec_digital_volume_soft_mute;
  logic clock = 1'b0; // 125 MHz system clock
  logic rst_b = 1'b0; // Held low for three cycles
  cdv_pkg::cdv_bus_req_type regReq = '0; // Register port request
  logic [7:0] regRdata;
  logic sampleFrameClock = 1'b0; // Frame clock pin, far slower than clock
  logic powerDownPin_b = 1'b1;
  logic adcRunning = 1'b0;
  cdv_pkg::cdv_levels_type gainLevel;
  logic [cdv_pkg::NUM_CH-1:0] rampBusy;
  cdv_pkg::cdv_deemph_type deemphasisSelect;
  int fails = 0;
  int nChecks = 0;
  int bigSteps = 0; // Ramp steps larger than one fine level
  logic [31:0] seed = 32'hf8980d44; // Fixed start keeps runs repeatable

  always #4 clock = ~clock;

  cdv_volume i_dut (
    .clock(clock),
    .rst_b(rst_b),
    .regReq(regReq),
    .regRdata(regRdata),
    .sampleFrameClock(sampleFrameClock),
    .powerDownPin_b(powerDownPin_b),
    .adcRunning(adcRunning),
    .gainLevel(gainLevel),
    .rampBusy(rampBusy),
    .deemphasisSelect(deemphasisSelect)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Expectation helpers
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    lfsrNext = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Volume code after reset: ADC channels first, then DAC
  function automatic logic [7:0] expRst(input int ch);
    expRst = (ch < 4) ? 8'h30 : 8'h18;
  endfunction
  // Four fine levels per half-decibel code
  function automatic logic [9:0] levelOf(input logic [7:0] code);
    levelOf = {code, 2'b00};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks
  task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkVal(input logic [9:0] got, input logic [9:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register port cycles, one-cycle strobes
  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regReq.addr <= a;
    regReq.wdata <= d;
    regReq.write <= 1'b1;
    @(posedge clock);
    regReq.write <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic regCheck(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    regReq.addr <= a;
    regReq.read <= 1'b1;
    @(posedge clock);
    regReq.read <= 1'b0;
    #1;
    chkReg(regRdata, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Frame pulses held long enough for the three-flop synchroniser
  task automatic runFrames(input int n);
    repeat (n)
    begin
      @(posedge clock);
      sampleFrameClock <= 1'b1;
      repeat (4) @(posedge clock);
      sampleFrameClock <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask
  // Frames until a channel settles; bounded so a stuck ramp cannot hang
  task automatic rampCount(input int ch, output int n);
    logic [9:0] prev;
    n = 0;
    #1;
    while (rampBusy[ch] === 1'b1 && n < 5000)
    begin
      prev = gainLevel[ch];
      runFrames(1);
      #1;
      n++;
      if (gainLevel[ch] - prev > 10'h001 && prev - gainLevel[ch] > 10'h001)
        bigSteps++;
    end
  endtask
  task automatic powerDown();
    @(posedge clock);
    powerDownPin_b <= 1'b0;
    repeat (8) @(posedge clock);
    powerDownPin_b <= 1'b1;
    repeat (8) @(posedge clock);
  endtask
  // Default codes, control and levels
  task automatic checkDefaults();
    for (int i = 0; i < 6; i++)
    begin
      regCheck(4'(i), expRst(i));
      chkVal(gainLevel[i], levelOf(expRst(i)));
    end
    regCheck(4'h6, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected 0.32 ms of traffic
  initial
  begin
    #600000;
    fails++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [7:0] vals [6];
    int n;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    checkDefaults();
    $display("test defaults done");
    // Random codes on all six volumes, then read back
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsrNext(seed);
      vals[i] = seed[7:0];
      regWrite(4'(i), vals[i]);
    end
    for (int i = 0; i < 6; i++)
      regCheck(4'(i), vals[i]);
    regCheck(4'h9, 8'h00); // Unmapped place reads zero
    for (int m = 0; m < 4; m++)
    begin
      regWrite(4'h6, 8'(m));
      regCheck(4'h6, 8'(m));
      chkVal(10'(deemphasisSelect), 10'(m));
    end
    $display("test registers done");
    // Power-down restores everything; status stays read-only
    powerDown();
    checkDefaults();
    regWrite(4'h7, 8'hff);
    regCheck(4'h7, 8'h00);
    $display("test power-down done");
    // Full code ramps at fast speed, one ADC and one DAC channel
    foreach (vals[ch])
    begin
      if (ch == 2 || ch == 5)
      begin
        regWrite(4'(ch), 8'h00);
        rampCount(ch, n);
        chkVal(10'(n), levelOf(expRst(ch)));
        regWrite(4'(ch), 8'hff);
        rampCount(ch, n);
        chkVal(10'(n), levelOf(8'hff));
      end
    end
    $display("test full ramps done");
    // Soft mute down and back from 0 dB
    powerDown();
    adcRunning <= 1'b1;
    // Controller order: mute, switch channel while silent, unmute
    regWrite(4'h6, 8'h80);
    rampCount(0, n);
    chkVal(10'(n), levelOf(8'hff) - levelOf(8'h30));
    chkVal(gainLevel[1], levelOf(8'hff));
    // Muted hold shortened far below a real channel settle time
    runFrames(4);
    regWrite(4'h6, 8'h00);
    rampCount(0, n);
    chkVal(10'(n), levelOf(8'hff) - levelOf(8'h30));
    chkVal(gainLevel[0], levelOf(8'h30));
    // Release part way: same rate back up
    regWrite(4'h6, 8'h80);
    runFrames(100);
    chkVal(gainLevel[0], levelOf(8'h30) + 10'd100);
    regWrite(4'h6, 8'h00);
    rampCount(0, n);
    chkVal(10'(n), 10'd100);
    // Stopped ADC ignores mute, running ADC then ramps
    @(posedge clock);
    adcRunning <= 1'b0;
    regWrite(4'h6, 8'h80);
    runFrames(20);
    chkVal(gainLevel[0], levelOf(8'h30));
    adcRunning <= 1'b1;
    runFrames(50);
    chkVal(gainLevel[0], levelOf(8'h30) + 10'd50);
    powerDown();
    chkVal(gainLevel[0], levelOf(8'h30));
    $display("test soft mute done");
    // Slow speed: four frames per step, divider phase unknown
    regWrite(4'h6, 8'h20);
    regWrite(4'h0, 8'h34);
    rampCount(0, n);
    chkVal(10'(n >= 61 && n <= 64), 10'd1);
    regWrite(4'h6, 8'h10);
    regWrite(4'h4, 8'h1c);
    rampCount(4, n);
    chkVal(10'(n >= 61 && n <= 64), 10'd1);
    chkVal(10'(bigSteps), 10'd0);
    $display("test slow speed done");
    tally_and_finish();
  end
endmodule // tb_codec_digital_volume_soft_mute
